// [core/rtca_pkg.sv]
// package of constants and types for the alarm repeat and match block
package rtca_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_ALARM_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_ALARM_TIME = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam int unsigned CTRL_EN_BIT = 15;
  localparam int unsigned CTRL_WRAP_BIT = 14;
  localparam logic [31:0] TIME_MASK = 32'h3f7f_7f00;
  localparam logic [7:0] RPT_RESET = 8'h00;
  localparam logic [7:0] RPT_MAX = 8'hff;
  localparam int unsigned SYNC_WIN_CYC = 32;

  typedef struct packed {
    logic [1:0] hours_tens_digit;
    logic [3:0] hours_units_digit;
    logic [2:0] minutes_tens_digit;
    logic [3:0] minutes_units_digit;
    logic [2:0] seconds_tens_digit;
    logic [3:0] seconds_units_digit;
  } rtca_time_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rtca_bus_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HIT = 2'b10
  } rtca_state_t;

  // pack time struct into register layout
  function automatic logic [31:0] rtca_pack(input rtca_time_t t);
    rtca_pack = {2'b00, t.hours_tens_digit, t.hours_units_digit, 1'b0, t.minutes_tens_digit,
                 t.minutes_units_digit, 1'b0, t.seconds_tens_digit, t.seconds_units_digit, 8'h00};
  endfunction

  // unpack register layout into time struct
  function automatic rtca_time_t rtca_unpack(input logic [31:0] w);
    rtca_unpack = '{w[29:28], w[27:24], w[22:20], w[19:16], w[14:12], w[11:8]};
  endfunction
endpackage

// [core/rtca_rpt_ctr.sv]
// repeat counter with wrap option and auto disable
`timescale 1ns/1ps
module rtca_rpt_ctr
  import rtca_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_val,
  input wire logic alarm_event,
  input wire logic repeat_wrap_enable,
  output logic [7:0] alarm_repeat_count,
  output logic last_hit
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire logic at_zero = (cnt_q == 8'h00);

  // decrement, wrap or hold at zero
  assign cnt_d = wr_en ? wr_val :
                 !alarm_event ? cnt_q :
                 !at_zero ? cnt_q - 8'h01 :
                 repeat_wrap_enable ? RPT_MAX : 8'h00;
  assign last_hit = alarm_event && at_zero && !repeat_wrap_enable;
  assign alarm_repeat_count = cnt_q;

  // count register, power-on reset only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= RPT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  repeat_dec_a: assert property (@(posedge core_clk) disable iff (rst)
    !wr_en && alarm_event && cnt_q != 8'h00 |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("repeat count did not decrement");
  repeat_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
    !wr_en && alarm_event && at_zero |=> cnt_q == ($past(repeat_wrap_enable) ? 8'hff : 8'h00))
    else $error("repeat count wrap wrong");
endmodule

// [core/rtca_alarm.sv]
// alarm repeat, enable and time match block with register port
`timescale 1ns/1ps
module rtca_alarm
  import rtca_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic clock_module_enable,
  input wire logic alarm_sync_flag,
  input wire logic [31:0] time_of_day,
  output logic alarm_event_q,
  output logic alarm_enable_q,
  output logic write_hazard_q
);
  rtca_bus_t bus;
  rtca_time_t alarm_time_q;
  rtca_time_t now;
  rtca_state_t state_q;
  rtca_state_t state_d;
  logic wrap_q;
  logic [7:0] rpt_cnt;
  logic last_hit;
  logic [31:0] rdata_d;
  logic sync_m_q;
  logic sync_q;
  logic en_d;
  logic time_eq;
  logic match;

  assign bus = '{reg_addr, reg_wdata, reg_wr, reg_rd};
  assign now = rtca_unpack(time_of_day);

  // address decode
  wire logic wr_ctrl = bus.wr && (bus.addr == OFF_ALARM_CTRL);
  wire logic wr_time = bus.wr && (bus.addr == OFF_ALARM_TIME);
  wire logic wr_stat = bus.wr && (bus.addr == OFF_STATUS);

  // time compare, hours minutes seconds
  assign time_eq = (rtca_pack(now) == rtca_pack(alarm_time_q));
  assign match = alarm_enable_q && time_eq && (state_q == ST_IDLE);

  // one event per matching second: wait for match to go away
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (match) begin
          state_d = ST_HIT;
        end
      end
      ST_HIT: begin
        if (!(time_eq && alarm_enable_q)) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  rtca_rpt_ctr u_rpt (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr_ctrl),
    .wr_val(bus.wdata[7:0]),
    .alarm_event(alarm_event_q),
    .repeat_wrap_enable(wrap_q),
    .alarm_repeat_count(rpt_cnt),
    .last_hit(last_hit)
  );

  // enable: hardware clear wins over software write
  assign en_d = last_hit ? 1'b0 :
                wr_ctrl ? bus.wdata[CTRL_EN_BIT] : alarm_enable_q;

  // register images and read selects
  wire logic [31:0] ctrl_image = {16'h0000, alarm_enable_q, wrap_q, 6'h00, rpt_cnt};
  wire logic [31:0] time_image = rtca_pack(alarm_time_q) & TIME_MASK;
  wire logic [31:0] stat_image = {29'h0, write_hazard_q, sync_q, state_q == ST_HIT};
  wire logic rd_ctrl = bus.rd && (bus.addr == OFF_ALARM_CTRL);
  wire logic rd_time = bus.rd && (bus.addr == OFF_ALARM_TIME);
  wire logic rd_stat = bus.rd && (bus.addr == OFF_STATUS);

  // read mux, zero when idle or unmapped
  assign rdata_d = rd_ctrl ? ctrl_image :
                   rd_time ? time_image :
                   rd_stat ? stat_image :
                   32'h0000_0000;

  // sync flag enters from another domain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_m_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      sync_m_q <= alarm_sync_flag;
      sync_q <= sync_m_q;
    end
  end

  // control and event registers, power-on reset only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_enable_q <= 1'b0;
      wrap_q <= 1'b0;
      state_q <= ST_IDLE;
      alarm_event_q <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      alarm_enable_q <= en_d;
      if (wr_ctrl) begin
        wrap_q <= bus.wdata[CTRL_WRAP_BIT];
      end
      state_q <= state_d;
      alarm_event_q <= match;
      reg_rdata <= rdata_d;
    end
  end

  // time register: no reset, contents undefined at power-on
  always_ff @(posedge core_clk) begin
    if (wr_time) begin
      alarm_time_q <= rtca_unpack(bus.wdata);
    end
  end

  // sticky flag for a count write during the sync window, set wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_hazard_q <= 1'b0;
    end else if (wr_ctrl && clock_module_enable && sync_q) begin
      write_hazard_q <= 1'b1;
    end else if (wr_stat && bus.wdata[2]) begin
      write_hazard_q <= 1'b0;
    end
  end

  // trigger tally since the last control write, checks the total count
  logic [7:0] tally_base_q;
  logic [8:0] tally_hits_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tally_base_q <= RPT_RESET;
      tally_hits_q <= 9'h000;
    end else if (wr_ctrl) begin
      tally_base_q <= bus.wdata[7:0];
      tally_hits_q <= 9'h000;
    end else if (alarm_event_q && tally_hits_q != 9'h1ff) begin
      tally_hits_q <= tally_hits_q + 9'h001;
    end
  end

  auto_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    alarm_event_q && rpt_cnt == 8'h00 && !wrap_q |=> !alarm_enable_q)
    else $error("enable not cleared on last alarm");
  event_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    alarm_event_q |-> $past(alarm_enable_q) && $past(time_eq))
    else $error("alarm event without match");
  match_fires_a: assert property (@(posedge core_clk) disable iff (rst)
    match |=> alarm_event_q)
    else $error("match did not raise event");
  one_event_a: assert property (@(posedge core_clk) disable iff (rst)
    alarm_event_q |=> !alarm_event_q)
    else $error("event longer than one cycle");
  time_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_ALARM_TIME |=> (reg_rdata & ~TIME_MASK) == 32'h0)
    else $error("unused time bits not zero");
  time_store_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_time |=> alarm_time_q.hours_tens_digit == $past(reg_wdata[29:28]))
    else $error("hours tens not stored");
  hazard_set_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_ctrl && clock_module_enable && sync_q |=> write_hazard_q)
    else $error("hazard flag not set");
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");

  // trigger count: all ones gives 256, zero gives one
  trigger_total_a: assert property (@(posedge core_clk) disable iff (rst)
    last_hit && !wr_ctrl |-> tally_hits_q == {1'b0, tally_base_q})
    else $error("wrong number of alarm triggers");

  // stored time digits
  store_hr_units_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_time |=> alarm_time_q.hours_units_digit == $past(reg_wdata[27:24]))
    else $error("hours units not stored");
  store_min_tens_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_time |=> alarm_time_q.minutes_tens_digit == $past(reg_wdata[22:20]))
    else $error("minutes tens not stored");
  store_min_units_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_time |=> alarm_time_q.minutes_units_digit == $past(reg_wdata[19:16]))
    else $error("minutes units not stored");
  store_sec_tens_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_time |=> alarm_time_q.seconds_tens_digit == $past(reg_wdata[14:12]))
    else $error("seconds tens not stored");
  store_sec_units_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_time |=> alarm_time_q.seconds_units_digit == $past(reg_wdata[11:8]))
    else $error("seconds units not stored");

  // read data images
  ctrl_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_ALARM_CTRL |=> reg_rdata[7:0] == $past(rpt_cnt))
    else $error("count read back wrong");
  ctrl_en_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_ALARM_CTRL |=> reg_rdata[15] == $past(alarm_enable_q))
    else $error("enable read back wrong");
  ctrl_wrap_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_ALARM_CTRL |=> reg_rdata[14] == $past(wrap_q))
    else $error("wrap read back wrong");
  ctrl_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_ALARM_CTRL |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[13:8] == 6'h00)
    else $error("unused control bits not zero");
  status_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[2] == $past(write_hazard_q))
    else $error("hazard read back wrong");
  sync_status_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[1] == $past(sync_q))
    else $error("sync read back wrong");
  stat_hit_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[0] == ($past(state_q) == ST_HIT))
    else $error("match state read back wrong");
  stat_bits_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STATUS |=> reg_rdata[31:3] == 29'h0)
    else $error("unused status bits not zero");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr != OFF_ALARM_CTRL && reg_addr != OFF_ALARM_TIME && reg_addr != OFF_STATUS
    |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  // control fields
  hw_clear_wins_a: assert property (@(posedge core_clk) disable iff (rst)
    last_hit && wr_ctrl |=> !alarm_enable_q)
    else $error("software write beat hardware clear");
  enable_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_ctrl && !last_hit |=> alarm_enable_q == $past(reg_wdata[15]))
    else $error("enable not written");
  enable_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !wr_ctrl && !last_hit |=> alarm_enable_q == $past(alarm_enable_q))
    else $error("enable changed by itself");
  wrap_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_ctrl |=> wrap_q == $past(reg_wdata[14]))
    else $error("wrap not written");
  wrap_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !wr_ctrl |=> wrap_q == $past(wrap_q))
    else $error("wrap changed by itself");
  count_write_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_ctrl |=> rpt_cnt == $past(reg_wdata[7:0]))
    else $error("count not written");
  count_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !wr_ctrl && !alarm_event_q |=> rpt_cnt == $past(rpt_cnt))
    else $error("count changed without event");
  last_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    last_hit && !wr_ctrl |=> rpt_cnt == 8'h00)
    else $error("count left zero without wrap");

  // write hazard flag
  hazard_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    wr_stat && reg_wdata[2] |=> !write_hazard_q)
    else $error("hazard flag not cleared");
  hazard_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    write_hazard_q && !wr_stat |=> write_hazard_q)
    else $error("hazard flag dropped");
  hazard_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    !write_hazard_q && !(wr_ctrl && clock_module_enable && sync_q) |=> !write_hazard_q)
    else $error("hazard flag set without cause");
  sync_stage_a: assert property (@(posedge core_clk) disable iff (rst)
    sync_q == $past(sync_m_q))
    else $error("sync stages out of order");

  // event sequencing
  rearm_a: assert property (@(posedge core_clk) disable iff (rst)
    state_q == ST_HIT && time_eq && alarm_enable_q |=> !alarm_event_q)
    else $error("event repeated within one match");
  hit_release_a: assert property (@(posedge core_clk) disable iff (rst)
    state_q == ST_HIT && !time_eq |=> state_q == ST_IDLE)
    else $error("match state not released");
  no_event_off_a: assert property (@(posedge core_clk) disable iff (rst)
    !alarm_enable_q |=> !alarm_event_q)
    else $error("event while disabled");
  event_state_a: assert property (@(posedge core_clk) disable iff (rst)
    alarm_event_q |-> state_q == ST_HIT)
    else $error("event outside match state");
  state_onehot_a: assert property (@(posedge core_clk) disable iff (rst)
    $onehot(state_q))
    else $error("match state not one hot");

  event_cov: cover property (@(posedge core_clk) disable iff (rst) alarm_event_q);
  clear_cov: cover property (@(posedge core_clk) disable iff (rst) last_hit);
  wrap_cov: cover property (@(posedge core_clk) disable iff (rst) alarm_event_q && wrap_q && rpt_cnt == 8'h00);
  hazard_cov: cover property (@(posedge core_clk) disable iff (rst) wr_ctrl && clock_module_enable && sync_q);
endmodule

// [sim/rtca_alarm_tb.sv]
// self-checking bench for the alarm repeat and match block
`timescale 1ns/1ps
module rtca_alarm_tb;
  import rtca_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, clock_module_enable, alarm_sync_flag;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, time_of_day, rd_val;
  logic alarm_event_q, alarm_enable_q, write_hazard_q;
  int fail_count = 0;
  int samples_checked = 0;
  int events = 0;
  localparam logic [31:0] ALM = 32'h2359_5900; // 23:59:59
  localparam logic [31:0] OFF = 32'h2359_5800;

  rtca_alarm uut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_module_enable(clock_module_enable),
    .alarm_sync_flag(alarm_sync_flag), .time_of_day(time_of_day), .alarm_event_q(alarm_event_q),
    .alarm_enable_q(alarm_enable_q), .write_hazard_q(write_hazard_q));

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // count alarm pulses
  always @(posedge core_clk) if (alarm_event_q === 1'b1) events++;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // one matching second, then the match goes away
  task automatic hit();
    @(posedge core_clk);
    time_of_day <= ALM;
    @(posedge core_clk);
    time_of_day <= OFF;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    clock_module_enable = 1'b0;
    alarm_sync_flag = 1'b0;
    time_of_day = OFF;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1 check({29'h0, alarm_event_q, alarm_enable_q, write_hazard_q}, 32'h0, "outputs after reset");
    rd(OFF_ALARM_CTRL, rd_val);
    check(rd_val & 32'h0000_c0ff, 32'h0, "control after reset");
    // field layout and unused bits
    wr(OFF_ALARM_TIME, 32'hffff_ffff);
    rd(OFF_ALARM_TIME, rd_val);
    check(rd_val, 32'h3f7f_7f00, "unused time bits");
    wr(OFF_ALARM_TIME, 32'h0908_0700);
    rd(OFF_ALARM_TIME, rd_val);
    check(rd_val, 32'h0908_0700, "time units digits");
    wr(OFF_ALARM_TIME, ALM);
    wr(4'hc, 32'h0);
    rd(OFF_ALARM_TIME, rd_val);
    check(rd_val, ALM, "time tens digits");
    rd(4'hc, rd_val);
    check(rd_val, 32'h0, "unmapped read");
    // count 1, no wrap: pulse timing, decrement, then auto disable
    wr(OFF_ALARM_CTRL, 32'h0000_8001);
    @(posedge core_clk);
    time_of_day <= ALM;
    @(posedge core_clk);
    time_of_day <= OFF;
    #1 check({31'h0, alarm_event_q}, 32'h1, "event pulse");
    @(posedge core_clk);
    #1 check({31'h0, alarm_event_q}, 32'h0, "event one cycle");
    rd(OFF_ALARM_CTRL, rd_val);
    check(rd_val & 32'h0000_c0ff, 32'h0000_8000, "count decremented");
    hit();
    check({31'h0, alarm_enable_q}, 32'h0, "enable cleared");
    rd(OFF_ALARM_CTRL, rd_val);
    check(rd_val & 32'h0000_c0ff, 32'h0, "count stays zero");
    hit();
    check(events, 2, "no event when disabled");
    // wrap at zero keeps the alarm running
    wr(OFF_ALARM_CTRL, 32'h0000_c000);
    hit();
    rd(OFF_ALARM_CTRL, rd_val);
    check(rd_val & 32'h0000_c0ff, 32'h0000_c0ff, "count wraps");
    // all ones gives 256 triggers
    wr(OFF_ALARM_CTRL, 32'h0000_80ff);
    events = 0;
    repeat (257) hit();
    check(events, 256, "trigger count");
    check({31'h0, alarm_enable_q}, 32'h0, "enable after last");
    // control write while enabled and synced
    clock_module_enable <= 1'b1;
    alarm_sync_flag <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(OFF_ALARM_CTRL, 32'h0000_0005);
    rd(OFF_STATUS, rd_val);
    check(rd_val & 32'h6, 32'h6, "hazard flagged");
    alarm_sync_flag <= 1'b0;
    wr(OFF_STATUS, 32'h4);
    rd(OFF_STATUS, rd_val);
    check(rd_val & 32'h6, 32'h0, "hazard cleared");
    check({31'h0, write_hazard_q}, 32'h0, "hazard output");
    // second reset keeps the time value
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd(OFF_ALARM_TIME, rd_val);
    check(rd_val, ALM, "time kept over reset");
    rd(OFF_ALARM_CTRL, rd_val);
    check(rd_val & 32'h0000_c0ff, 32'h0, "control reset");
    finish_test();
  end
endmodule
